// *** design/sep_core.sv ***
// Purpose: serial eeprom instruction decoder, write latch, status and array read
// Assumes: link clock sck_i idles between frames; cs_n_i high ends a frame
// Notes: link logic runs on sck_i, latch and timer logic on clk_i
//
// Summary of operation
// - codes x110 set latch, x100 clear it
// - writes ignored unless write latch set
// - latch cleared by reset, clear, writes, guard
// - after latch commands wait for deselect
// - status read accepted at any time
// - busy bit reads one during write
// - latch bit read only, status write ignores
// - protect bits choose protected upper region
// - protect bits frozen until write ends
// - status write needs exactly sixteen clocks
// - upper nibble fixed, protect bits writable
// - protect bits start at zero
// - read: instruction then address byte
// - low bits 011 read, 010 write
// - read data leaves on falling edges
// - address advances after each byte
// - address wraps to zero past top
// - deselect ends a read
// - read during write cycle is rejected
// - nine address bits used for 512 bytes
// - unknown instruction deselects until next select
// - msb first, first rising edge after select
// - output released while deselected
`timescale 1ns/1ps
`default_nettype none

module sep_core
   import sep_pkg::*;
(
   input wire logic clk_i,            // system clock
   input wire logic srst_i,           // synchronous reset
   input wire logic sck_i,            // link shift clock
   input wire logic cs_n_i,           // chip select, active low
   input wire logic si_i,             // serial data in
   input wire logic write_guard_n_i,  // write guard pin, active low
   output logic so_o,                 // serial data out
   output logic so_oe_o               // serial out drive enable
);

   // ==========================================================
   // storage and state
   // ==========================================================
   logic [7:0] mem [0:MEM_BYTES-1];    // array contents
   sep_frame_type fr_q;                // per-frame link state
   sep_frame_type fr_d;
   sep_hold_type hd_q;                 // held link requests
   sep_hold_type hd_d;
   sep_out_type ou_q;                  // output stage
   sep_out_type ou_d;
   sep_ctl_type ct_q;                  // system side state
   sep_ctl_type ct_d;
   logic frame_rst;                    // clears link frame state
   logic mem_we;                       // array write strobe

   // ==========================================================
   // helpers
   // ==========================================================
   // status byte from its fields
   function automatic logic [7:0] stat_byte(input logic [1:0] bp,
                                            input logic write_latch_flag,
                                            input logic busy);
      stat_byte = {STAT_HI, bp, write_latch_flag, busy};
   endfunction

   // latch command kind of a complete instruction byte
   function automatic sep_req_type latch_kind(input logic [7:0] b);
      latch_kind = RQ_NONE;
      if (b[7:4] == 4'h0) begin
         if (b[2:0] == OP_SET) begin
            latch_kind = RQ_SET;
         end else if (b[2:0] == OP_CLR) begin
            latch_kind = RQ_CLR;
         end
      end
   endfunction

   // address lies inside the protected region
   function automatic logic is_prot(input logic [8:0] a, input logic [1:0] bp);
      unique case (bp)
         2'h0: is_prot = 1'b0;
         2'h1: is_prot = (a >= QTR_BASE);
         2'h2: is_prot = (a >= HALF_BASE);
         2'h3: is_prot = 1'b1;
      endcase
   endfunction

   // deselect or startup clears the frame state at once
   // deselect ends read
   assign frame_rst = cs_n_i | ct_q.link_rst;

   // ==========================================================
   // link frame logic, rising edge of sck_i
   // ==========================================================
   // next frame state from the sampled input bit
   always_comb begin
      logic [7:0] shn;
      logic done;
      shn = {fr_q.sh[6:0], si_i};
      done = (fr_q.bit_i == 3'h7);
      fr_d = fr_q;
      fr_d.sh = shn;
      fr_d.bit_i = fr_q.bit_i + 3'h1;
      fr_d.tx = {fr_q.tx[6:0], 1'b0};
      if (fr_q.cnt != CNT_MAX) begin
         fr_d.cnt = fr_q.cnt + 5'h01;
      end
      unique case (fr_q.st)
         // instruction byte
         ST_CMD: begin
            if (done) begin
               fr_d.st = ST_WAIT;
               fr_d.addr = {shn[OP_TOP_BIT], 8'h00};
               if (shn[7:4] == 4'h0) begin
                  unique case (shn[2:0])
                     OP_SRD: begin
                        fr_d.st = ST_SREAD;
                        fr_d.tx = stat_byte(ct_q.bp, hd_q.wel2, hd_q.bsy2);
                     end
                     OP_ARD: begin
                        fr_d.st = hd_q.bsy2 ? ST_WAIT : ST_RADDR;
                     end
                     OP_SWR: fr_d.st = ST_WSTAT;
                     OP_AWR: begin
                        fr_d.st = hd_q.bsy2 ? ST_WAIT : ST_WADDR;
                     end
                     OP_SET: fr_d.st = ST_WAIT;
                     OP_CLR: fr_d.st = ST_WAIT;
                     default: fr_d.st = ST_WAIT;
                  endcase
               end
            end
         end
         ST_RADDR: begin
            if (done) begin
               fr_d.st = ST_RDATA;
               fr_d.tx = mem[{fr_q.addr[8], shn}];
               fr_d.addr = {fr_q.addr[8], shn} + 9'h001;
            end
         end
         ST_RDATA: begin
            if (done) begin
               fr_d.tx = mem[fr_q.addr];
               fr_d.addr = fr_q.addr + 9'h001;
            end
         end
         ST_SREAD: begin
            if (done) begin
               fr_d.tx = stat_byte(ct_q.bp, hd_q.wel2, hd_q.bsy2);
            end
         end
         // status data byte
         ST_WSTAT: begin
            if (done) begin
               fr_d.st = ST_WAIT;
            end
         end
         // write address byte
         ST_WADDR: begin
            if (done) begin
               fr_d.st = ST_WDATA;
               fr_d.addr = {fr_q.addr[8], shn};
            end
         end
         // write data byte
         ST_WDATA: begin
            if (done) begin
               fr_d.st = ST_WAIT;
            end
         end
         // ignore input until deselect
         ST_WAIT: begin
            fr_d.st = ST_WAIT;
         end
      endcase
   end

   // frame registers, cleared whenever deselected
   always_ff @(posedge sck_i or posedge frame_rst) begin
      if (frame_rst) begin
         fr_q <= FRAME_RST;
      end else begin
         fr_q <= fr_d;
      end
   end

   // ==========================================================
   // held requests and status sync, rising edge of sck_i
   // ==========================================================
   // requests stay stable after deselect for the system side
   always_comb begin
      logic [7:0] shn;
      shn = {fr_q.sh[6:0], si_i};
      hd_d = hd_q;
      // two-stage sync of busy and latch into the link clock
      hd_d.bsy1 = ct_q.busy;
      hd_d.bsy2 = hd_q.bsy1;
      hd_d.wel1 = ct_q.write_latch_flag;
      hd_d.wel2 = hd_q.wel1;
      // a new frame drops any stale request
      if (fr_q.cnt == 5'h00) begin
         hd_d.kind = RQ_NONE;
      end
      if (fr_q.st == ST_CMD && fr_q.bit_i == 3'h7) begin
         hd_d.kind = latch_kind(shn);
      end
      if (fr_q.st == ST_WSTAT && fr_q.cnt == CNT_SWR_LAST) begin
         hd_d.kind = RQ_SWR;
         hd_d.data = shn;
      end
      // array write on edge twenty-four
      if (fr_q.st == ST_WDATA && fr_q.cnt == CNT_AWR_LAST) begin
         hd_d.kind = RQ_AWR;
         hd_d.data = shn;
         hd_d.addr = fr_q.addr;
      end
      if ((hd_q.kind == RQ_SWR && fr_q.cnt == CNT_SWR_OVER) ||
          (hd_q.kind == RQ_AWR && fr_q.cnt == CNT_AWR_OVER)) begin
         hd_d.kind = RQ_NONE;
      end
   end

   // held registers, cleared only at startup
   always_ff @(posedge sck_i or posedge ct_q.link_rst) begin
      if (ct_q.link_rst) begin
         hd_q <= HOLD_RST;
      end else begin
         hd_q <= hd_d;
      end
   end

   // ==========================================================
   // output stage, falling edge of sck_i
   // ==========================================================
   // drive the top bit while a read phase is active
   always_comb begin
      ou_d.so = fr_q.tx[7];
      ou_d.oe = (fr_q.st == ST_SREAD) || (fr_q.st == ST_RDATA);
   end

   always_ff @(negedge sck_i or posedge frame_rst) begin
      if (frame_rst) begin
         ou_q <= OUT_RST;
      end else begin
         ou_q <= ou_d;
      end
   end

   assign so_o = ou_q.so;
   assign so_oe_o = ou_q.oe;

   // ==========================================================
   // system side: latch, busy timer, protect bits
   // ==========================================================
   // commit requests when the synchronised select rises
   always_comb begin
      logic rise;
      logic fall;
      ct_d = ct_q;
      mem_we = 1'b0;
      ct_d.link_rst = 1'b0;
      ct_d.cs1 = cs_n_i;
      ct_d.cs2 = ct_q.cs1;
      ct_d.cs3 = ct_q.cs2;
      ct_d.g1 = write_guard_n_i;
      ct_d.g2 = ct_q.g1;
      rise = ct_q.cs2 & ~ct_q.cs3;
      fall = ~ct_q.cs2 & ct_q.cs3;
      // a select is needed before the first command counts
      if (fall) begin
         ct_d.armed = 1'b1;
      end
      if (ct_q.busy) begin
         ct_d.timer = ct_q.timer - 16'h0001;
         if (ct_q.timer == 16'h0000) begin
            ct_d.busy = 1'b0;
            ct_d.write_latch_flag = 1'b0;
            if (ct_q.pkind == RQ_SWR) begin
               ct_d.bp = ct_q.pdata[BP_POS+1:BP_POS];
            end else begin
               mem_we = 1'b1;
            end
         end
      end
      // held request is stable once the link clock has stopped
      if (rise && ct_q.armed) begin
         unique case (hd_q.kind)
            RQ_SET: ct_d.write_latch_flag = 1'b1;
            RQ_CLR: ct_d.write_latch_flag = 1'b0;
            RQ_SWR: begin
               if (ct_q.write_latch_flag && !ct_q.busy) begin
                  ct_d.busy = 1'b1;
                  ct_d.timer = WRITE_CYC - 16'h0001;
                  ct_d.pkind = RQ_SWR;
                  ct_d.pdata = hd_q.data;
               end
            end
            RQ_AWR: begin
               if (ct_q.write_latch_flag && !ct_q.busy) begin
                  if (is_prot(hd_q.addr, ct_q.bp)) begin
                     ct_d.write_latch_flag = 1'b0;
                  end else begin
                     ct_d.busy = 1'b1;
                     ct_d.timer = WRITE_CYC - 16'h0001;
                     ct_d.pkind = RQ_AWR;
                     ct_d.pdata = hd_q.data;
                     ct_d.paddr = hd_q.addr;
                  end
               end
            end
            RQ_NONE: ct_d.write_latch_flag = ct_d.write_latch_flag;
            default: ct_d.write_latch_flag = ct_d.write_latch_flag;
         endcase
      end
      if (!ct_q.g2) begin
         ct_d.write_latch_flag = 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         ct_q <= CTL_RST;
      end else begin
         ct_q <= ct_d;
      end
   end

   // array write at the end of the timed cycle
   always_ff @(posedge clk_i) begin
      if (mem_we) begin
         mem[ct_q.paddr] <= ct_q.pdata;
      end
   end

endmodule // sep_core

`default_nettype wire

// *** common/sep_pkg.sv ***
// Purpose: shared constants and state types of the serial eeprom core
// Assumes: 512-byte array, 50 MHz system clock
// Notes: opcodes compare the low three bits with the upper nibble zero
package sep_pkg;

   // ==========================================================
   // geometry and timing
   // ==========================================================
   localparam int ADDR_W = 9;            // byte address width
   localparam int MEM_BYTES = 512;       // array size
   localparam int CLK_PERIOD_NS = 20;    // system clock period
   localparam int WRITE_TIME_NS = 5000;  // self-timed write duration
   localparam logic [15:0] WRITE_CYC = 16'((WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

   // ==========================================================
   // instruction codes (low three bits)
   // ==========================================================
   localparam logic [2:0] OP_SET = 3'h6;   // set write latch
   localparam logic [2:0] OP_CLR = 3'h4;   // clear write latch
   localparam logic [2:0] OP_SRD = 3'h5;   // status read
   localparam logic [2:0] OP_SWR = 3'h1;   // status write
   localparam logic [2:0] OP_ARD = 3'h3;   // array read
   localparam logic [2:0] OP_AWR = 3'h2;   // array write
   localparam int OP_TOP_BIT = 3;          // position of top address bit

   // ==========================================================
   // status byte layout
   // ==========================================================
   localparam logic [3:0] STAT_HI = 4'hF;  // fixed upper nibble
   localparam logic [1:0] BP_RST = 2'h0;   // protect bits as delivered
   localparam int BP_POS = 2;              // protect field low bit
   localparam logic [8:0] QTR_BASE = 9'h180;  // upper quarter start
   localparam logic [8:0] HALF_BASE = 9'h100; // upper half start

   // ==========================================================
   // bit counts at the link
   // ==========================================================
   localparam logic [4:0] CNT_SWR_LAST = 5'h0F;  // edge 16 minus one
   localparam logic [4:0] CNT_SWR_OVER = 5'h10;  // edge 17 minus one
   localparam logic [4:0] CNT_AWR_LAST = 5'h17;  // edge 24 minus one
   localparam logic [4:0] CNT_AWR_OVER = 5'h18;  // edge 25 minus one
   localparam logic [4:0] CNT_MAX = 5'h1F;       // saturation value

   // ==========================================================
   // states and request kinds
   // ==========================================================
   typedef enum logic [2:0] {
      ST_CMD = 3'h0, ST_RADDR = 3'h1, ST_RDATA = 3'h2, ST_SREAD = 3'h3,
      ST_WSTAT = 3'h4, ST_WADDR = 3'h5, ST_WDATA = 3'h6, ST_WAIT = 3'h7
   } sep_state_type;

   typedef enum logic [2:0] {
      RQ_NONE = 3'h0, RQ_SET = 3'h1, RQ_CLR = 3'h2, RQ_SWR = 3'h3, RQ_AWR = 3'h4
   } sep_req_type;

   // per-frame link state, cleared while deselected
   typedef struct packed {
      sep_state_type st;
      logic [2:0] bit_i;
      logic [4:0] cnt;
      logic [7:0] sh;
      logic [8:0] addr;
      logic [7:0] tx;
   } sep_frame_type;

   // link state that survives deselection
   typedef struct packed {
      sep_req_type kind;
      logic [7:0] data;
      logic [8:0] addr;
      logic bsy1;
      logic bsy2;
      logic wel1;
      logic wel2;
   } sep_hold_type;

   // falling-edge output stage
   typedef struct packed {
      logic so;
      logic oe;
   } sep_out_type;

   // system clock side
   typedef struct packed {
      logic cs1;
      logic cs2;
      logic cs3;
      logic g1;
      logic g2;
      logic link_rst;
      logic armed;
      logic write_latch_flag;
      logic busy;
      logic [15:0] timer;
      logic [1:0] bp;
      sep_req_type pkind;
      logic [7:0] pdata;
      logic [8:0] paddr;
   } sep_ctl_type;

   localparam sep_frame_type FRAME_RST = '{st: ST_CMD, default: '0};
   localparam sep_hold_type HOLD_RST = '{kind: RQ_NONE, default: '0};
   localparam sep_out_type OUT_RST = '{default: '0};
   localparam sep_ctl_type CTL_RST = '{cs1: 1'b1, cs2: 1'b1, cs3: 1'b1,
      g1: 1'b1, g2: 1'b1, link_rst: 1'b1, bp: BP_RST, pkind: RQ_NONE, default: '0};

endpackage

// *** tb/sep_assertions.sv ***
// Purpose: pin level checks of the serial eeprom core
// Assumes: link clock idles low between frames
// Notes: frame tracking clears while the chip is deselected
`timescale 1ns/1ps
`default_nettype none

module sep_assertions
   import sep_pkg::*;
(
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic sck_i,
   input wire logic cs_n_i,
   input wire logic si_i,
   input wire logic write_guard_n_i,
   input wire logic so_o,
   input wire logic so_oe_o
);
   // ==========================================================
   // frame tracking
   // ==========================================================
   logic [5:0] cnt_q; // rises seen in this frame, saturating
   logic [7:0] ins_q; // instruction byte
   logic is_srd;      // frame is a status read
   logic is_ard;      // frame is an array read

   // count rises and shift in the instruction, cleared by deselect
   always_ff @(posedge sck_i or posedge cs_n_i) begin
      if (cs_n_i) begin
         cnt_q <= 6'h00;
         ins_q <= 8'h00;
      end else begin
         cnt_q <= (cnt_q == 6'h3F) ? cnt_q : cnt_q + 6'h01;
         ins_q <= (cnt_q < 6'h08) ? {ins_q[6:0], si_i} : ins_q;
      end
   end

   assign is_srd = (ins_q[7:4] == 4'h0) && (ins_q[2:0] == OP_SRD);
   assign is_ard = (ins_q[7:4] == 4'h0) && (ins_q[2:0] == OP_ARD);

   // ==========================================================
   // properties
   // ==========================================================
   sequence s_srd_body;
      (cnt_q >= 6'h08) && is_srd;
   endsequence
   sequence s_rd_head;
      (cnt_q < 6'h10) && is_ard;
   endsequence

   a_head_quiet: assert property (@(posedge sck_i) disable iff (srst_i)
      (cnt_q < 6'h08) |-> !so_oe_o) else $error("drive during instruction byte");
   a_srd_drive: assert property (@(posedge sck_i) disable iff (srst_i)
      s_srd_body |-> so_oe_o) else $error("status read not driven");
   a_srd_ones: assert property (@(posedge sck_i) disable iff (srst_i)
      s_srd_body ##0 (cnt_q[2:0] < 3'h4) |-> so_o) else $error("upper status bits not one");
   a_srd_repeat: assert property (@(posedge sck_i) disable iff (srst_i)
      s_srd_body ##0 (cnt_q >= 6'h10 && cnt_q[2:0] < 3'h6) |-> so_o == $past(so_o, 8))
      else $error("status byte not repeated");
   a_rd_wait: assert property (@(posedge sck_i) disable iff (srst_i)
      s_rd_head |-> !so_oe_o) else $error("read data before address done");
   a_other_quiet: assert property (@(posedge sck_i) disable iff (srst_i)
      (cnt_q >= 6'h08 && !is_srd && !is_ard) |-> !so_oe_o) else $error("drive in silent frame");
   a_desel_float: assert property (@(posedge clk_i) disable iff (srst_i)
      cs_n_i |-> !so_oe_o) else $error("drive while deselected");
   a_so_steady: assert property (@(posedge clk_i) disable iff (srst_i)
      (sck_i && $past(sck_i) && so_oe_o && $past(so_oe_o)) |-> $stable(so_o))
      else $error("output moved while clock high");
endmodule // sep_assertions

bind sep_core sep_assertions u_sep_chk (.clk_i(clk_i), .srst_i(srst_i), .sck_i(sck_i),
   .cs_n_i(cs_n_i), .si_i(si_i), .write_guard_n_i(write_guard_n_i), .so_o(so_o),
   .so_oe_o(so_oe_o));

`default_nettype wire

// *** tb/sep_master.sv ***
// Purpose: mode 0 link master driving the serial eeprom pins
// Assumes: 160 ns link clock, idle low outside frames
// Notes: bits seen while the output floats are captured as z
`timescale 1ns/1ps
`default_nettype none

module sep_master (
   output logic sck_o,
   output logic cs_n_o,
   output logic si_o,
   input wire logic so_i,
   input wire logic so_oe_i
);
   event done;        // raised as each frame ends
   logic [63:0] rx_q; // bits taken on rising edges

   // idle bus at time zero
   initial begin
      sck_o = 1'b0;
      cs_n_o = 1'b1;
      si_o = 1'b0;
      rx_q = '0;
   end

   // one framed transfer of n bits, msb first
   task automatic xfer(input logic [63:0] tx, input int n);
      rx_q = '0;
      #3.3 cs_n_o = 1'b0;
      #40;
      for (int i = n - 1; i >= 0; i--) begin
         si_o = tx[i];
         #80 sck_o = 1'b1;
         rx_q = {rx_q[62:0], so_oe_i ? so_i : 1'bz};
         #80 sck_o = 1'b0;
      end
      // deselect between last fall and next rise
      #40 cs_n_o = 1'b1;
      si_o = ~si_o;
      -> done;
      #200;
   endtask
endmodule // sep_master

`default_nettype wire

// *** tb/testbench.sv ***
// Purpose: self-checking bench for the serial eeprom core
// Assumes: link master model drives the pins in mode 0
// Notes: expected frames queue up and are compared as each frame ends
`timescale 1ns/1ps
`default_nettype none

module testbench;
   import sep_pkg::*;
   logic clk_i;            // system clock
   logic srst_i;           // synchronous reset
   logic write_guard_n_i;  // guard pin, active low
   logic sck;              // link clock
   logic cs_n;             // chip select, active low
   logic si;               // serial data in
   logic so;               // serial data out
   logic so_oe;            // core drives so
   int errors;             // mismatches
   int compares;           // comparisons
   int seed;               // random seed
   logic [1:0] bp;         // expected protect field
   logic [7:0] mem [512];  // expected array
   logic [63:0] exp_q [$]; // expected frames
   logic [8:0] addrs [5] = '{9'h0FF, 9'h17F, 9'h180, 9'h1FF, 9'h000};
   logic [7:0] bad [4] = '{8'h00, 8'h0F, 8'h10, 8'h85};

   sep_master m (.sck_o(sck), .cs_n_o(cs_n), .si_o(si), .so_i(so), .so_oe_i(so_oe));
   sep_core dut (.clk_i(clk_i), .srst_i(srst_i), .sck_i(sck), .cs_n_i(cs_n), .si_i(si),
      .write_guard_n_i(write_guard_n_i), .so_o(so), .so_oe_o(so_oe));

   // ==========================================================
   // clock and helpers
   // ==========================================================
   initial clk_i = 1'b0;
   always #10 clk_i = ~clk_i;

   task automatic check(input string name, input logic [63:0] seen, input logic [63:0] expv);
      compares++;
      if (seen !== expv) begin
         errors++;
         $display("wrong value %s expected %h seen %h", name, expv, seen);
      end
   endtask

   task automatic results();
      if (errors == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // n bits, the first zb of them undriven
   function automatic logic [63:0] ex(input int n, input int zb, input logic [63:0] v);
      logic [63:0] r;
      r = '0;
      for (int i = 0; i < n; i++) r[i] = (i < n - zb) ? v[i] : 1'bz;
      return r;
   endfunction

   function automatic bit prot(input logic [8:0] a);
      return bp == 2'h3 || (bp == 2'h2 && a >= 9'h100) || (bp == 2'h1 && a >= 9'h180);
   endfunction

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask

   // note the expectation, then run the frame
   task automatic xf(input logic [63:0] tx, input int n, input logic [63:0] expv);
      exp_q.push_back(expv);
      m.xfer(tx, n);
   endtask

   task automatic srd(input logic w, input logic b);
      logic [7:0] st;
      st = {4'hF, bp, w, b};
      xf(64'h050000, 24, ex(24, 8, {st, st}));
   endtask

   task automatic wr(input logic [8:0] a, input logic [7:0] d, input bit en, input bit probe);
      if (en)
         xf(64'h06, 8, ex(8, 8, '0));
      xf({40'h0, 4'h0, a[8], OP_AWR, a[7:0], d}, 24, ex(24, 24, '0));
      if (probe) begin
         // 17 rises expose a wrongly accepted read and keep the status frame
         // after it inside the timed write
         xf({47'h0, 4'h0, a[8], OP_ARD, a[7:0], 1'b0}, 17, ex(17, 17, '0));
         xf(64'h0500, 16, ex(16, 8, {4'hF, bp, 2'h3}));
      end
      if (en && !prot(a))
         mem[a] = d;
      wait_cyc(300);
   endtask

   task automatic rd(input logic [8:0] a, input int nb, input int n);
      logic [63:0] v;
      v = '0;
      for (int i = 0; i < nb; i++) v = {v[55:0], mem[a + 9'(i)]};
      xf(64'({4'h0, a[8], OP_ARD, a[7:0]}) << (n - 16), n,
         ex(n, 16, v >> (16 + 8 * nb - n)));
   endtask

   task automatic swr(input logic [7:0] d);
      xf(64'h06, 8, ex(8, 8, '0));
      xf({48'h0, 8'h01, d}, 16, ex(16, 16, '0));
      wait_cyc(300);
      bp = d[3:2];
   endtask

   // compare each finished frame with the oldest note
   always @(m.done) begin
      check("frame", m.rx_q, exp_q.pop_front());
   end

   // ==========================================================
   // main sequence
   // ==========================================================
   initial begin
      srst_i = 1'b1;
      write_guard_n_i = 1'b1;
      errors = 0;
      compares = 0;
      seed = 32'h34620320;
      bp = 2'h0;
      repeat (16) @(posedge clk_i);
      #1 srst_i = 1'b0;
      wait_cyc(8);
      srd(1'b0, 1'b0);
      xf(64'h0E, 8, ex(8, 8, '0));
      srd(1'b1, 1'b0);
      xf(64'h0C, 8, ex(8, 8, '0));
      srd(1'b0, 1'b0);
      xf(64'h06, 8, ex(8, 8, '0));
      xf(64'h0406, 16, ex(16, 16, '0));
      srd(1'b0, 1'b0);
      xf(64'h010C, 16, ex(16, 16, '0));
      srd(1'b0, 1'b0);
      xf(64'h06, 8, ex(8, 8, '0));
      xf(64'h0218, 17, ex(17, 17, '0));
      xf(64'h04, 8, ex(8, 8, '0));
      srd(1'b0, 1'b0);
      xf(64'h06, 8, ex(8, 8, '0));
      xf(64'h01FF, 16, ex(16, 16, '0));
      srd(1'b1, 1'b1);
      wait_cyc(300);
      bp = 2'h3;
      srd(1'b0, 1'b0);
      xf(64'h06, 8, ex(8, 8, '0));
      srd(1'b1, 1'b0);
      write_guard_n_i = 1'b0;
      wait_cyc(5);
      write_guard_n_i = 1'b1;
      wait_cyc(5);
      srd(1'b0, 1'b0);
      for (int k = 0; k < 5; k++) begin
         swr({4'h0, 2'(k % 4), 2'h0});
         foreach (addrs[j]) wr(addrs[j], 8'($random(seed)), 1'b1, 1'b0);
         rd(9'h0FF, 1, 24);
         rd(9'h17F, 2, 32);
         rd(9'h1FF, 2, 32);
      end
      wr(9'h0FF, 8'h5A, 1'b0, 1'b0);
      rd(9'h0FF, 1, 24);
      wr(9'h000, 8'hC3, 1'b1, 1'b1);
      rd(9'h000, 1, 24);
      rd(9'h0FF, 1, 20);
      srd(1'b0, 1'b0);
      foreach (bad[j]) xf({48'h0, bad[j], 8'h05}, 16, ex(16, 16, '0));
      srd(1'b0, 1'b0);
      results();
   end

   // cut a hang short
   initial begin
      // nearly twice the longest expected run
      #1000000;
      errors++;
      results();
   end
endmodule // testbench

`default_nettype wire
